// File: hw/rbc_map.vh
`ifndef RBC_MAP_VH
`define RBC_MAP_VH

// sequencer states
`define RBC_ST_HOLD       2'h0
`define RBC_ST_WAKE       2'h1
`define RBC_ST_FLASH      2'h2
`define RBC_ST_RUN        2'h3

// wake-up timer length in oscillator-good clocks
`define RBC_WAKE_CYCLES   4096
`define RBC_WAKE_W        13

// reset cause bit positions
`define RBC_CAUSE_PIN     0
`define RBC_CAUSE_WDOG    1
`define RBC_CAUSE_POR     2
`define RBC_CAUSE_BOD     3
`define RBC_CAUSE_RST     4'h4

// synchronised input bit positions
`define RBC_IN_PIN_N      6
`define RBC_IN_POR_OK     5
`define RBC_IN_OSC_OK     4
`define RBC_IN_WARN_LO    3
`define RBC_IN_WARN_HI    2
`define RBC_IN_BOD_LO     1
`define RBC_IN_BOD_HI     0
`define RBC_IN_W          7
`define RBC_IN_RST        7'h0a

// first fetch address after release
`define RBC_BOOT_ADDR     32'h00000000

`endif

// File: hw/rbc_reset_brownout_control.v
`timescale 1ns/10ps
`default_nettype none
`include "rbc_map.vh"

module rbc_reset_brownout_control #(
	parameter WAKE_CYCLES = `RBC_WAKE_CYCLES
) (
	// clock and power-on reset
	input  wire        core_clk,
	input  wire        rstn,
	// reset sources
	input  wire        ext_reset_pin_n,
	input  wire        wdog_timeout,
	input  wire        por_ok,
	// oscillator and flash
	input  wire        osc_running,
	input  wire        flash_init_done,
	// brownout_detector comparators
	input  wire        sup_below_warn,
	input  wire        sup_above_warn_hys,
	input  wire        sup_below_bod,
	input  wire        sup_above_bod_hys,
	// reset outputs
	output reg         reset_out_pin,
	output reg         chip_reset_n,
	output reg         periph_reset_n,
	output reg         flash_init_start,
	// brownout warning
	output reg         brownout_warn_irq,
	output reg         brownout_warn_status,
	// boot and cause
	output reg  [31:0] boot_fetch_addr,
	output reg         boot_block_map,
	output reg  [3:0]  reset_cause
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	wire                     arst_n;
	wire [`RBC_IN_W-1:0]     raw_in;
	reg  [`RBC_IN_W-1:0]     sync1_reg;
	reg  [`RBC_IN_W-1:0]     sync2_reg;
	reg  [`RBC_IN_W-1:0]     sync3_reg;
	reg  [`RBC_IN_W-1:0]     filt_reg;
	wire [`RBC_IN_W-1:0]     filt_next;
	wire                     pin_n_f;
	wire                     por_f;
	wire                     osc_f;
	wire                     warn_lo_f;
	wire                     warn_hi_f;
	wire                     bod_lo_f;
	wire                     bod_hi_f;
	reg                      warn_reg;
	reg                      bod_rst_reg;
	wire [3:0]               src_vec;
	wire                     src_active;
	reg  [1:0]               state_reg;
	reg  [1:0]               state_next;
	reg  [`RBC_WAKE_W-1:0]   cnt_reg;
	reg  [`RBC_WAKE_W-1:0]   cnt_next;
	reg                      start_next;
	reg                      rearm_reg;
	wire                     run_next;
	wire                     out_next;
	wire [`RBC_WAKE_W-1:0]   wake_last_w;

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// set on the low trip, clear only past the upper trip, set wins
	function hys_next(input cur, input below, input above);
		begin
			if (below)
				hys_next = 1'b1;
			else if (above)
				hys_next = 1'b0;
			else
				hys_next = cur;
		end
	endfunction

	// sequencer state decode
	function is_run(input [1:0] st);
		begin
			is_run = (st == `RBC_ST_RUN);
		end
	endfunction

	// last count of the wake-up timer, cut to counter width
	function [`RBC_WAKE_W-1:0] wake_last(input integer n);
		integer t;
		begin
			t         = n - 1;
			wake_last = t[`RBC_WAKE_W-1:0];
		end
	endfunction

	assign wake_last_w = wake_last(WAKE_CYCLES);

	////////////////////////////////////////////////////////////////////////////////
	// asynchronous assertion path

	// pin or power loss drops reset at once
	assign arst_n = rstn & ext_reset_pin_n & por_ok;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers

	assign raw_in = {ext_reset_pin_n, por_ok, osc_running,
		sup_below_warn, sup_above_warn_hys, sup_below_bod, sup_above_bod_hys};

	// a change counts once stages two and three agree
	assign filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
		(filt_reg & (sync2_reg ^ sync3_reg));

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= `RBC_IN_RST;
			sync2_reg <= `RBC_IN_RST;
			sync3_reg <= `RBC_IN_RST;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// filtered copy of the synchronised inputs
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			filt_reg <= `RBC_IN_RST;
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign pin_n_f   = filt_reg[`RBC_IN_PIN_N];
	assign por_f     = filt_reg[`RBC_IN_POR_OK];
	assign osc_f     = filt_reg[`RBC_IN_OSC_OK];
	assign warn_lo_f = filt_reg[`RBC_IN_WARN_LO];
	assign warn_hi_f = filt_reg[`RBC_IN_WARN_HI];
	assign bod_lo_f  = filt_reg[`RBC_IN_BOD_LO];
	assign bod_hi_f  = filt_reg[`RBC_IN_BOD_HI];

	////////////////////////////////////////////////////////////////////////////////
	// two-stage brownout monitor

	// set on the low trip, clear only past the upper trip
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			warn_reg    <= 1'b1;
			bod_rst_reg <= 1'b1;
		end else begin
			warn_reg    <= hys_next(warn_reg, warn_lo_f, warn_hi_f);
			bod_rst_reg <= hys_next(bod_rst_reg, bod_lo_f, bod_hi_f);
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			brownout_warn_irq    <= 1'b0;
			brownout_warn_status <= 1'b0;
		end else begin
			brownout_warn_irq    <= warn_reg;
			brownout_warn_status <= warn_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset source merge

	assign src_vec[`RBC_CAUSE_PIN]  = ~pin_n_f;
	assign src_vec[`RBC_CAUSE_WDOG] = wdog_timeout;
	assign src_vec[`RBC_CAUSE_POR]  = ~por_f;
	assign src_vec[`RBC_CAUSE_BOD]  = bod_rst_reg;
	assign src_active = |src_vec;

	// armed by a run, so a pin or supply drop that clears the
	// sequencer at once still restarts the cause
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rearm_reg <= 1'b0;
		end else if (is_run(state_reg)) begin
			rearm_reg <= 1'b1;
		end else if (src_active) begin
			rearm_reg <= 1'b0;
		end
	end

	// sticky cause, restarted when a new reset begins after run
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reset_cause <= `RBC_CAUSE_RST;
		end else if (src_active && rearm_reg) begin
			reset_cause <= src_vec;
		end else if (!is_run(state_reg)) begin
			reset_cause <= reset_cause | src_vec;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wake-up sequencer

	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		start_next = 1'b0;
		case (state_reg)
			`RBC_ST_HOLD: begin
				cnt_next = {`RBC_WAKE_W{1'b0}};
				if (!src_active)
					state_next = `RBC_ST_WAKE;
			end
			`RBC_ST_WAKE: begin
				// oscillator must stay good for the whole count
				if (!osc_f) begin
					cnt_next = {`RBC_WAKE_W{1'b0}};
				end else if (cnt_reg == wake_last_w) begin
					state_next = `RBC_ST_FLASH;
					start_next = 1'b1;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			`RBC_ST_FLASH: begin
				if (flash_init_done)
					state_next = `RBC_ST_RUN;
			end
			`RBC_ST_RUN: begin
			end
			default: begin
				state_next = `RBC_ST_HOLD;
			end
		endcase
		// any source restarts the wake-up timer
		if (src_active) begin
			state_next = `RBC_ST_HOLD;
			cnt_next   = {`RBC_WAKE_W{1'b0}};
			start_next = 1'b0;
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg        <= `RBC_ST_HOLD;
			cnt_reg          <= {`RBC_WAKE_W{1'b0}};
			flash_init_start <= 1'b0;
		end else begin
			state_reg        <= state_next;
			cnt_reg          <= cnt_next;
			flash_init_start <= start_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset outputs

	// after a brownout the pin also waits for supply above threshold
	assign run_next = is_run(state_next);

	assign out_next = run_next &&
		!(reset_cause[`RBC_CAUSE_BOD] && bod_lo_f);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reset_out_pin  <= 1'b0;
			chip_reset_n   <= 1'b0;
			periph_reset_n <= 1'b0;
		end else begin
			reset_out_pin  <= out_next;
			chip_reset_n   <= run_next;
			periph_reset_n <= run_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// boot vector

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_fetch_addr <= `RBC_BOOT_ADDR;
			boot_block_map  <= 1'b1;
		end else begin
			boot_fetch_addr <= `RBC_BOOT_ADDR;
			boot_block_map  <= 1'b1;
		end
	end

endmodule // rbc_reset_brownout_control

`default_nettype wire

// File: dv/rbc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_chk #(
	parameter WAKE_CYCLES = 8
) (
	// clock and power-on reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// sources and supply
	input wire logic        ext_reset_pin_n,
	input wire logic        wdog_timeout,
	input wire logic        por_ok,
	input wire logic        osc_running,
	input wire logic        flash_init_done,
	input wire logic        sup_below_warn,
	input wire logic        sup_above_warn_hys,
	input wire logic        sup_below_bod,
	input wire logic        sup_above_bod_hys,
	// outputs
	input wire logic        reset_out_pin,
	input wire logic        chip_reset_n,
	input wire logic        periph_reset_n,
	input wire logic        flash_init_start,
	input wire logic        brownout_warn_irq,
	input wire logic        brownout_warn_status,
	input wire logic [31:0] boot_fetch_addr,
	input wire logic        boot_block_map,
	input wire logic [3:0]  reset_cause
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_SRC: assert property ((!ext_reset_pin_n || !por_ok) |-> !chip_reset_n && !reset_out_pin)
		else $error("reset released under pin or supply reset");
	AST_WDOG: assert property (wdog_timeout |-> ##[1:2] !chip_reset_n)
		else $error("watchdog did not reset");
	AST_REL: assert property ($rose(chip_reset_n) |-> $past(flash_init_done) && ext_reset_pin_n)
		else $error("release without flash done");
	AST_OSC: assert property ($rose(chip_reset_n) |-> $past(osc_running, WAKE_CYCLES))
		else $error("release without stable oscillator");
	AST_PULSE: assert property (flash_init_start |=> !flash_init_start && !chip_reset_n)
		else $error("flash start not a pulse");
	AST_OUT: assert property ($rose(reset_out_pin) |-> chip_reset_n && !sup_below_bod)
		else $error("reset out rose early");
	AST_BOOT: assert property (chip_reset_n |-> boot_fetch_addr == 32'h0 && boot_block_map)
		else $error("boot address wrong");
	AST_PERIPH: assert property (periph_reset_n == chip_reset_n)
		else $error("peripheral reset differs");
	AST_WARN: assert property (sup_below_warn [*8] |-> brownout_warn_irq && brownout_warn_status)
		else $error("warning missing");
	AST_BOD: assert property (sup_below_bod [*8] |-> !chip_reset_n && !reset_out_pin)
		else $error("brownout did not reset");
	AST_HYS: assert property ($fell(brownout_warn_status) |-> $past(sup_above_warn_hys, 3))
		else $error("warning cleared inside hysteresis");
endmodule // rbc_chk
bind rbc_reset_brownout_control rbc_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);
`default_nettype wire

// File: dv/rbc_supply_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_supply_model (
	// clock and bench commands
	input  wire logic       core_clk,
	input  wire logic       pin_req,
	input  wire logic [8:0] vdd_cv,
	// flash handshake
	input  wire logic       flash_init_start,
	output var  logic       flash_init_done,
	// pins and comparators
	output var  logic       ext_reset_pin_n,
	output var  logic       por_ok,
	output var  logic       osc_running,
	output var  logic       sup_below_warn,
	output var  logic       sup_above_warn_hys,
	output var  logic       sup_below_bod,
	output var  logic       sup_above_bod_hys
);
	int fcnt = 0;
	initial flash_init_done = 1'b0;
	always @(negedge core_clk) begin
		ext_reset_pin_n <= !pin_req;
		por_ok <= vdd_cv >= 9'd100;
		osc_running <= vdd_cv >= 9'd100;
		sup_below_warn <= vdd_cv < 9'd220;
		sup_above_warn_hys <= vdd_cv > 9'd230;
		sup_below_bod <= vdd_cv < 9'd185;
		sup_above_bod_hys <= vdd_cv > 9'd195;
		if (flash_init_start) begin
			fcnt <= 5;
			flash_init_done <= 1'b0;
		end else if (fcnt > 0) begin
			fcnt <= fcnt - 1;
			flash_init_done <= fcnt == 1;
		end
	end
endmodule // rbc_supply_model
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        core_clk = 0, rstn = 0, wdog_timeout = 0, pin_req = 0, cr_q = 0;
	logic [8:0]  vdd_cv = 9'd330;
	logic [31:0] lfsr = 32'h4f9811a3;
	logic [3:0]  q[$];
	logic [3:0]  tab[4] = '{4'h2, 4'h1, 4'hc, 4'h8};
	int          n_mismatch = 0, n_checks = 0, cyc = 0, k;
	wire         ext_reset_pin_n, por_ok, osc_running, flash_init_done, flash_init_start;
	wire         sup_below_warn, sup_above_warn_hys, sup_below_bod, sup_above_bod_hys;
	wire         reset_out_pin, chip_reset_n, periph_reset_n, boot_block_map;
	wire         brownout_warn_irq, brownout_warn_status;
	wire [31:0]  boot_fetch_addr;
	wire [3:0]   reset_cause;
	rbc_reset_brownout_control #(.WAKE_CYCLES(8)) dut (.*);
	rbc_supply_model u_model (.*);
	always #2 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task test_done;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task recover(input logic [3:0] c);
		int i;
		q.push_back(c);
		chk(chip_reset_n, 1'b0);
		for (i = 0; i < 300 && chip_reset_n !== 1'b1; i++) @(negedge core_clk);
		chk(reset_out_pin, 1'b1);
		repeat (4) @(negedge core_clk);
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			test_done();
		end
	end
	always @(negedge core_clk) begin
		cr_q <= chip_reset_n;
		if (chip_reset_n === 1'b1 && cr_q === 1'b0) begin
			if (q[0] != 4'hf) chk(reset_cause, q[0]);
			chk(boot_fetch_addr, 32'h0);
			chk(periph_reset_n, 1'b1);
			void'(q.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge core_clk);
		rstn = 1;
		recover(4'hf);
		for (k = 0; k < 8; k++) begin
			lfsr = nxt(lfsr);
			case (k % 4)
				0: wdog_timeout = 1;
				1: pin_req = 1;
				2: vdd_cv = 9'd90;
				default: vdd_cv = 9'd180;
			endcase
			repeat (10 + lfsr[2:0]) @(negedge core_clk);
			chk(chip_reset_n, 1'b0);
			chk(reset_out_pin, 1'b0);
			wdog_timeout = 0;
			pin_req = 0;
			vdd_cv = 9'd190;
			repeat (12) @(negedge core_clk);
			if (k % 4 == 3) chk(chip_reset_n, 1'b0);
			vdd_cv = 9'd330;
			recover(tab[k % 4]);
		end
		vdd_cv = 9'd210;
		repeat (12) @(negedge core_clk);
		chk({brownout_warn_irq, brownout_warn_status}, 2'b11);
		vdd_cv = 9'd221 + lfsr[3:0] % 9;
		repeat (12) @(negedge core_clk);
		chk(brownout_warn_status, 1'b1);
		vdd_cv = 9'd240;
		repeat (12) @(negedge core_clk);
		chk({brownout_warn_irq, brownout_warn_status, chip_reset_n}, 3'b001);
		test_done();
	end
endmodule // testbench
`default_nettype wire
